// file: inc/swm_defines.svh
`ifndef SWM_DEFINES_SVH
`define SWM_DEFINES_SVH

// ********************************************************
// Clock and time base
// ********************************************************
`define SWM_CLK_MHZ 200
`define SWM_US_CYC (`SWM_CLK_MHZ * 1)

// ********************************************************
// Line timing in microseconds
// ********************************************************
`define SWM_RST_LOW_US 480
`define SWM_RST_HIGH_US 480
`define SWM_PRES_SAMPLE_US 70
`define SWM_W0_LOW_US 60
`define SWM_W1_LOW_US 6
`define SWM_RD_LOW_US 6
`define SWM_RD_SAMPLE_US 13
`define SWM_SLOT_US 70

// ********************************************************
// Command codes and identity layout
// ********************************************************
`define SWM_CMD_READ 8'h33
`define SWM_CMD_SEARCH 8'hf0
`define SWM_CMD_BITS 8
`define SWM_ID_BITS 64
`define SWM_CRC_POLY 8'h8c
`define SWM_CRC_INIT 8'h00

`endif

// file: inc/swm_pkg.sv
package swm_pkg;
   typedef enum logic [1:0] {
      SWM_SLOT_RST = 2'h0,
      SWM_SLOT_WR = 2'h1,
      SWM_SLOT_RD = 2'h2
   } swm_slot_e;

   typedef enum logic {
      SWM_OP_READ = 1'h0,
      SWM_OP_SEARCH = 1'h1
   } swm_op_e;

   typedef enum logic [1:0] {
      SWM_E_IDLE = 2'b01,
      SWM_E_BUSY = 2'b10
   } swm_eng_e;

   typedef enum logic [6:0] {
      SWM_S_IDLE = 7'b0000001,
      SWM_S_RST = 7'b0000010,
      SWM_S_CMD = 7'b0000100,
      SWM_S_RDID = 7'b0001000,
      SWM_S_SRA = 7'b0010000,
      SWM_S_SRB = 7'b0100000,
      SWM_S_SRW = 7'b1000000
   } swm_state_e;
endpackage : swm_pkg

// file: inc/swm_slot_if.sv
`timescale 1ns/1ps
`default_nettype none

interface swm_slot_if;
   import swm_pkg::*;
   logic req;
   swm_slot_e kind;
   logic wbit;
   logic done;
   logic rbit;
   logic oe;
   logic line_in;

   modport master (output req, output kind, output wbit, output line_in,
                   input done, input rbit, input oe);
   modport engine (input req, input kind, input wbit, input line_in,
                   output done, output rbit, output oe);
endinterface : swm_slot_if

`default_nettype wire

// file: verilog/swm_slot_engine.sv
`timescale 1ns/1ps
`default_nettype none
`include "swm_defines.svh"

module swm_slot_engine #(parameter int US_CYC = `SWM_US_CYC) (
   input wire logic clk_sys, // System clock
   input wire logic rst_n, // Async reset, active low
   swm_slot_if.engine s // Slot request and line
);
   import swm_pkg::*;

   swm_eng_e state_reg, state_next;
   logic [9:0] cnt_reg, cnt_next;
   logic [7:0] div_reg, div_next;
   logic oe_reg, oe_next;
   logic done_reg, done_next;
   logic rbit_reg, rbit_next;
   logic tick;
   logic [9:0] low_t, samp_t, end_t;

   // ********************************************************
   // Slot shapes in microseconds
   // ********************************************************
   always_comb begin
      unique case (s.kind)
         SWM_SLOT_RST: begin
            low_t = 10'(`SWM_RST_LOW_US);
            samp_t = 10'(`SWM_RST_LOW_US + `SWM_PRES_SAMPLE_US);
            end_t = 10'(`SWM_RST_LOW_US + `SWM_RST_HIGH_US);
         end
         SWM_SLOT_WR: begin
            low_t = s.wbit ? 10'(`SWM_W1_LOW_US)
                           : 10'(`SWM_W0_LOW_US);
            samp_t = 10'(`SWM_SLOT_US);
            end_t = 10'(`SWM_SLOT_US);
         end
         default: begin
            low_t = 10'(`SWM_RD_LOW_US);
            samp_t = 10'(`SWM_RD_SAMPLE_US);
            end_t = 10'(`SWM_SLOT_US);
         end
      endcase
   end

   // One-microsecond enable; restarted at each slot so timing is exact
   assign tick = (div_reg == 8'(US_CYC - 1));

   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      div_next = div_reg;
      oe_next = oe_reg;
      done_next = 1'b0;
      rbit_next = rbit_reg;
      unique case (state_reg)
         SWM_E_IDLE: begin
            oe_next = 1'b0;
            if (s.req) begin
               state_next = SWM_E_BUSY;
               cnt_next = 10'h000;
               div_next = 8'h00;
               oe_next = 1'b1;
            end
         end
         SWM_E_BUSY: begin
            if (tick) begin
               div_next = 8'h00;
               cnt_next = cnt_reg + 10'h001;
            end else begin
               div_next = div_reg + 8'h01;
            end
            // Only ever pulls low; release lets the pull-up win
            oe_next = (cnt_next < low_t);
            if (tick && cnt_next == samp_t) begin
               rbit_next = s.line_in;
            end
            if (tick && cnt_next == end_t) begin
               done_next = 1'b1;
               state_next = SWM_E_IDLE;
               oe_next = 1'b0;
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= SWM_E_IDLE;
         cnt_reg <= 10'h000;
         div_reg <= 8'h00;
         oe_reg <= 1'b0;
         done_reg <= 1'b0;
         rbit_reg <= 1'b1;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         div_reg <= div_next;
         oe_reg <= oe_next;
         done_reg <= done_next;
         rbit_reg <= rbit_next;
      end
   end

   assign s.oe = oe_reg;
   assign s.done = done_reg;
   assign s.rbit = rbit_reg;

   // ********************************************************
   // Checks
   // ********************************************************
   chk_idle_released: assert property (@(posedge clk_sys) disable iff (!rst_n)
      state_reg == SWM_E_IDLE && !s.req |=> !oe_reg)
      else $error("line driven while engine idle");
   chk_slot_falls: assert property (@(posedge clk_sys) disable iff (!rst_n)
      state_reg == SWM_E_IDLE && s.req |=> oe_reg && cnt_reg == 10'h000)
      else $error("slot did not start with a falling edge");
   chk_w0_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
      state_reg == SWM_E_BUSY && s.kind == SWM_SLOT_WR && !s.wbit &&
      cnt_reg < 10'h03c |-> oe_reg)
      else $error("write zero released early");
   chk_w1_short: assert property (@(posedge clk_sys) disable iff (!rst_n)
      state_reg == SWM_E_BUSY && s.kind == SWM_SLOT_WR && s.wbit &&
      cnt_reg >= 10'h006 |-> !oe_reg)
      else $error("write one held too long");
   chk_reset_low: assert property (@(posedge clk_sys) disable iff (!rst_n)
      state_reg == SWM_E_BUSY && s.kind == SWM_SLOT_RST &&
      cnt_reg < 10'h1e0 |-> oe_reg)
      else $error("reset pulse shorter than 480 us");
   chk_slot_length: assert property (@(posedge clk_sys) disable iff (!rst_n)
      done_reg && s.kind != SWM_SLOT_RST |-> cnt_reg == 10'h046)
      else $error("slot length wrong");
endmodule : swm_slot_engine

`default_nettype wire

// file: verilog/swm_master.sv
// Operation
// - Check byte uses polynomial x^8 + x^5 + x^4 + 1.
// - CRC register starts at zero; bits enter family LSB first.
// - Shifting all 64 bits through the CRC leaves zero when valid.
// - One master only; device answers, never starts, except presence.
// - Every slot starts with a falling edge driven by the master.
// - Line driven only open-drain, giving a wired-AND.
// - Master stays below 16.3 kbit/s at standard speed.
// - Line idles high; low beyond 120 us may reset slaves.
// - Every transaction starts with reset then presence pulse.
// - After presence, send one 8-bit command, one bit per slot.
// - Read identity only with a single slave on the bus.
// - Search F0h: per bit read true, read complement, write choice.
// - Both read bits zero marks a branch; master picks one.
// - Reset pulse low at least 480 us, then sample presence.
// - Write zero low 60-120 us, write one low 1-15 us.
`timescale 1ns/1ps
`default_nettype none
`include "swm_defines.svh"

module swm_master #(parameter int US_CYC = `SWM_US_CYC) (
   input wire logic clk_sys, // System clock, 200 MHz
   input wire logic rst_n, // Async reset, active low
   input wire logic op_valid, // Start an operation
   input wire swm_pkg::swm_op_e op_code, // Read identity or search pass
   input wire logic [63:0] search_path, // Branch choice per bit
   output logic op_ready, // Idle, operation may start
   output logic op_done, // One-cycle end of operation
   output logic present, // A device answered
   output logic [63:0] rom_id, // Identity code, bit 0 first
   output logic [63:0] branch_mask, // Bits where both values seen
   output logic crc_ok, // Check byte matched
   input wire logic line_in, // Line level, synchronous
   output logic line_out, // Line drive value, always low
   output logic line_oe // Pull line low when high
);
   import swm_pkg::*;

   swm_slot_if slot_bus ();

   swm_slot_engine #(.US_CYC(US_CYC)) u_engine (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .s(slot_bus.engine)
   );

   // ********************************************************
   // Sequencer state
   // ********************************************************
   swm_state_e state_reg, state_next;
   swm_op_e op_reg, op_next;
   logic [5:0] idx_reg, idx_next;
   logic [7:0] cmd_reg, cmd_next;
   logic [7:0] crc_reg, crc_next;
   logic [63:0] id_reg, id_next;
   logic [63:0] bmask_reg, bmask_next;
   logic bit_a_reg, bit_a_next;
   logic req_reg, req_next;
   swm_slot_e kind_reg, kind_next;
   logic wbit_reg, wbit_next;
   logic ready_reg, ready_next;
   logic done_reg, done_next;
   logic pres_reg, pres_next;
   logic crcok_reg, crcok_next;
   logic line_out_reg;
   logic dir;
   logic [7:0] crc_step;
   logic [7:0] crc_after;

   // Bit-serial CRC, LSB first, reflected form of the polynomial
   function automatic logic [7:0] crc_shift(input logic [7:0] c,
                                            input logic b);
      logic fb;
      fb = c[0] ^ b;
      crc_shift = {1'b0, c[7:1]} ^ (fb ? `SWM_CRC_POLY : 8'h00);
   endfunction : crc_shift

   always_comb begin
      // Search direction: agreed bit, or the caller's path at a branch
      if (!bit_a_reg && !slot_bus.rbit) begin
         dir = search_path[idx_reg];
      end else begin
         dir = bit_a_reg;
      end
   end

   assign crc_step = crc_shift(crc_reg,
                               state_reg == SWM_S_SRB ? dir : slot_bus.rbit);
   assign crc_after = crc_step;

   always_comb begin
      state_next = state_reg;
      op_next = op_reg;
      idx_next = idx_reg;
      cmd_next = cmd_reg;
      crc_next = crc_reg;
      id_next = id_reg;
      bmask_next = bmask_reg;
      bit_a_next = bit_a_reg;
      req_next = 1'b0;
      kind_next = kind_reg;
      wbit_next = wbit_reg;
      done_next = 1'b0;
      pres_next = pres_reg;
      crcok_next = crcok_reg;
      unique case (state_reg)
         SWM_S_IDLE: begin
            if (op_valid) begin
               // A fresh reset restarts any device left ignoring slots
               op_next = op_code;
               req_next = 1'b1;
               kind_next = SWM_SLOT_RST;
               crc_next = `SWM_CRC_INIT;
               id_next = 64'h0;
               bmask_next = 64'h0;
               idx_next = 6'h00;
               crcok_next = 1'b0;
               state_next = SWM_S_RST;
            end
         end
         SWM_S_RST: begin
            if (slot_bus.done) begin
               pres_next = !slot_bus.rbit;
               if (slot_bus.rbit) begin
                  done_next = 1'b1;
                  state_next = SWM_S_IDLE;
               end else begin
                  // Read only suits a lone slave; the CRC exposes collisions
                  cmd_next = (op_reg == SWM_OP_READ) ? `SWM_CMD_READ
                                                     : `SWM_CMD_SEARCH;
                  req_next = 1'b1;
                  kind_next = SWM_SLOT_WR;
                  wbit_next = cmd_next[0];
                  state_next = SWM_S_CMD;
               end
            end
         end
         SWM_S_CMD: begin
            if (slot_bus.done) begin
               req_next = 1'b1;
               if (idx_reg == 6'(`SWM_CMD_BITS - 1)) begin
                  idx_next = 6'h00;
                  kind_next = SWM_SLOT_RD;
                  state_next = (op_reg == SWM_OP_READ) ? SWM_S_RDID
                                                       : SWM_S_SRA;
               end else begin
                  idx_next = idx_reg + 6'h01;
                  cmd_next = {1'b0, cmd_reg[7:1]};
                  wbit_next = cmd_next[0];
               end
            end
         end
         SWM_S_RDID: begin
            if (slot_bus.done) begin
               id_next = {slot_bus.rbit, id_reg[63:1]};
               crc_next = crc_after;
               if (idx_reg == 6'h3f) begin
                  crcok_next = (crc_after == 8'h00);
                  done_next = 1'b1;
                  state_next = SWM_S_IDLE;
               end else begin
                  idx_next = idx_reg + 6'h01;
                  req_next = 1'b1;
               end
            end
         end
         SWM_S_SRA: begin
            if (slot_bus.done) begin
               bit_a_next = slot_bus.rbit;
               req_next = 1'b1;
               kind_next = SWM_SLOT_RD;
               state_next = SWM_S_SRB;
            end
         end
         SWM_S_SRB: begin
            if (slot_bus.done) begin
               if (bit_a_reg && slot_bus.rbit) begin
                  // Nobody still taking part: the pass is void
                  pres_next = 1'b0;
                  done_next = 1'b1;
                  state_next = SWM_S_IDLE;
               end else begin
                  bmask_next[idx_reg] = !bit_a_reg && !slot_bus.rbit;
                  id_next = {dir, id_reg[63:1]};
                  crc_next = crc_after;
                  req_next = 1'b1;
                  kind_next = SWM_SLOT_WR;
                  wbit_next = dir;
                  state_next = SWM_S_SRW;
               end
            end
         end
         SWM_S_SRW: begin
            if (slot_bus.done) begin
               if (idx_reg == 6'h3f) begin
                  crcok_next = (crc_reg == 8'h00);
                  done_next = 1'b1;
                  state_next = SWM_S_IDLE;
               end else begin
                  idx_next = idx_reg + 6'h01;
                  req_next = 1'b1;
                  kind_next = SWM_SLOT_RD;
                  state_next = SWM_S_SRA;
               end
            end
         end
      endcase
      ready_next = (state_next == SWM_S_IDLE);
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= SWM_S_IDLE;
         op_reg <= SWM_OP_READ;
         idx_reg <= 6'h00;
         cmd_reg <= 8'h00;
         crc_reg <= `SWM_CRC_INIT;
         id_reg <= 64'h0;
         bmask_reg <= 64'h0;
         bit_a_reg <= 1'b0;
         req_reg <= 1'b0;
         kind_reg <= SWM_SLOT_RST;
         wbit_reg <= 1'b1;
         ready_reg <= 1'b1;
         done_reg <= 1'b0;
         pres_reg <= 1'b0;
         crcok_reg <= 1'b0;
         line_out_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         op_reg <= op_next;
         idx_reg <= idx_next;
         cmd_reg <= cmd_next;
         crc_reg <= crc_next;
         id_reg <= id_next;
         bmask_reg <= bmask_next;
         bit_a_reg <= bit_a_next;
         req_reg <= req_next;
         kind_reg <= kind_next;
         wbit_reg <= wbit_next;
         ready_reg <= ready_next;
         done_reg <= done_next;
         pres_reg <= pres_next;
         crcok_reg <= crcok_next;
         line_out_reg <= 1'b0;
      end
   end

   // The master is the only slot starter; the device merely answers
   assign slot_bus.req = req_reg;
   assign slot_bus.kind = kind_reg;
   assign slot_bus.wbit = wbit_reg;
   assign slot_bus.line_in = line_in;

   assign op_ready = ready_reg;
   assign op_done = done_reg;
   assign present = pres_reg;
   assign rom_id = id_reg;
   assign branch_mask = bmask_reg;
   assign crc_ok = crcok_reg;
   assign line_out = line_out_reg;
   assign line_oe = slot_bus.oe;

   // ********************************************************
   // Checks
   // ********************************************************
   chk_start_reset: assert property (@(posedge clk_sys) disable iff (!rst_n)
      op_valid && ready_reg |=> req_reg && kind_reg == SWM_SLOT_RST)
      else $error("operation did not open with reset");
   chk_cmd_writes: assert property (@(posedge clk_sys) disable iff (!rst_n)
      state_reg == SWM_S_CMD && req_reg |-> kind_reg == SWM_SLOT_WR &&
      wbit_reg == cmd_reg[0])
      else $error("command bit mismatch");
   chk_search_dir: assert property (@(posedge clk_sys) disable iff (!rst_n)
      state_reg == SWM_S_SRB && slot_bus.done &&
      (bit_a_reg ^ slot_bus.rbit) |=> wbit_reg == $past(bit_a_reg))
      else $error("search wrote wrong direction");
   chk_crc_verdict: assert property (@(posedge clk_sys) disable iff (!rst_n)
      done_reg && crcok_reg |-> crc_reg == 8'h00)
      else $error("crc flagged good but residue not zero");

   cov_read_ok: cover property (@(posedge clk_sys) disable iff (!rst_n)
      done_reg && op_reg == SWM_OP_READ && crcok_reg);
   cov_search_ok: cover property (@(posedge clk_sys) disable iff (!rst_n)
      done_reg && op_reg == SWM_OP_SEARCH && pres_reg);
   cov_absent: cover property (@(posedge clk_sys) disable iff (!rst_n)
      done_reg && !pres_reg);
endmodule : swm_master

`default_nettype wire

// file: sim/swm_dev_model.sv
`timescale 1ns/1ps
`default_nettype none

// ********************************************************
// Identity device model on the shared line
// ********************************************************
module swm_dev_model #(
   parameter logic [7:0] FAMILY = 8'h5a, // Arbitrary value
   parameter logic [47:0] SERIAL = 48'h0, // Serial number
   parameter int US_NS = 1000 // Nanoseconds per line microsecond
) (
   input wire logic line, // Wired-AND line level
   input wire logic en, // Device attached to the line
   output logic pull // Pulls the line low when high
);
   // Write sample point and read-zero hold, well past the 13 us master sample
   localparam int SMP_NS = 30 * US_NS;
   // Any low above this counts as a reset; write-zero is at most 120 us
   localparam int RST_NS = 300 * US_NS;
   typedef enum logic [1:0] {DM_WAIT, DM_CMD, DM_READ, DM_SRCH} swm_dm_e;
   swm_dm_e st = DM_WAIT;
   logic [63:0] id;
   logic [7:0] crc;
   logic [7:0] cmd;
   logic smp;
   logic d0;
   int cnt;
   int ph;
   realtime t0;

   initial begin
      id = {8'h00, SERIAL, FAMILY};
      crc = 8'h00;
      for (int i = 0; i < 56; i++) begin
         crc = {1'b0, crc[7:1]} ^
               ((crc[0] ^ id[i]) ? 8'h8c : 8'h00);
      end
      id[63:56] = crc;
   end

   initial begin
      pull = 1'b0;
      forever begin
         // Own presence pull is no slot start
         @(negedge line iff !pull);
         t0 = $realtime;
         d0 = en && ((st == DM_READ && !id[cnt]) ||
              (st == DM_SRCH && ph < 2 && id[cnt] == ph[0]));
         pull = d0;
         #(SMP_NS);
         smp = line;
         pull = 1'b0;
         if (!line) @(posedge line);
         if ($realtime - t0 > RST_NS) begin
            st = DM_CMD;
            cnt = 0;
            ph = 0;
            cmd = 8'h00;
            #(SMP_NS);
            pull = en;
            #(4 * SMP_NS);
            pull = 1'b0;
         end else begin
            case (st)
               DM_CMD: begin
                  cmd = {smp, cmd[7:1]};
                  cnt++;
                  if (cnt == 8) begin
                     cnt = 0;
                     if (cmd == 8'h33 || cmd == 8'h0f) st = DM_READ;
                     else if (cmd == 8'hf0) st = DM_SRCH;
                     else st = DM_WAIT;
                  end
               end
               DM_READ: begin
                  cnt++;
                  if (cnt == 64) st = DM_WAIT;
               end
               DM_SRCH: begin
                  if (ph < 2) ph++;
                  else begin
                     ph = 0;
                     cnt++;
                     // Losing the written bit drops out, so does a full pass
                     if (smp !== id[cnt-1] || cnt == 64) begin
                        st = DM_WAIT;
                     end
                  end
               end
               default: ;
            endcase
         end
      end
   end
endmodule : swm_dev_model

`default_nettype wire

// file: sim/swm_master_tb.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin \
   n_tests++; \
   if ((got) !== (exp)) begin \
      miscompares++; \
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); \
   end \
end

module swm_master_tb;
   import swm_pkg::*;
   // ********************************************************
   // Devices, line and design
   // ********************************************************
   localparam logic [7:0] FAM = 8'h5a; // Arbitrary value
   localparam logic [47:0] SER_A = 48'h0123_4567_89ab;
   localparam logic [47:0] SER_B = 48'h8123_4567_89a3;
   // Fast time base, one cycle per line microsecond, keeps the run short
   localparam int US_CYC = 1;
   typedef struct {
      swm_op_e op;
      logic ea;
      logic eb;
      logic [63:0] path;
   } swm_row_s;
   logic clk_sys, rst_n, op_valid, op_ready, op_done, present, crc_ok;
   logic line_out, line_oe, pull_a, pull_b, en_a, en_b, pres;
   swm_op_e op_code;
   logic [63:0] search_path, rom_id, branch_mask, ida, idb, eid, ebr;
   int n_tests = 0;
   int miscompares = 0;
   int run_len = 0;
   int max_low = 0;
   int gap = 1000000;
   int min_gap = 1000000;
   swm_row_s rows [5];
   wire logic line_w = !(line_oe | pull_a | pull_b);

   swm_master #(.US_CYC(US_CYC)) u_swm_master (.clk_sys(clk_sys),
      .rst_n(rst_n),
      .op_valid(op_valid), .op_code(op_code), .search_path(search_path),
      .op_ready(op_ready), .op_done(op_done), .present(present),
      .rom_id(rom_id), .branch_mask(branch_mask), .crc_ok(crc_ok),
      .line_in(line_w), .line_out(line_out), .line_oe(line_oe));
   swm_dev_model #(.FAMILY(FAM), .SERIAL(SER_A), .US_NS(5 * US_CYC))
      u_swm_dev_model_a (.line(line_w), .en(en_a), .pull(pull_a));
   swm_dev_model #(.FAMILY(FAM), .SERIAL(SER_B), .US_NS(5 * US_CYC))
      u_swm_dev_model_b (.line(line_w), .en(en_b), .pull(pull_b));

   // ********************************************************
   // Reference functions and tasks
   // ********************************************************
   function automatic logic [7:0] crc8(input logic [63:0] v, input int n);
      logic [7:0] c;
      logic fb;
      c = 8'h00;
      for (int i = 0; i < n; i++) begin
         fb = c[0] ^ v[i];
         c = {fb, c[7:1]};
         c[3] = c[3] ^ fb;
         c[2] = c[2] ^ fb;
      end
      return c;
   endfunction : crc8

   // Wired-AND search over the attached devices, branching on path
   function automatic void ref_search(input logic [63:0] a, b,
      input logic ea, eb, input logic [63:0] path,
      output logic [63:0] id, output logic [63:0] br);
      logic t, c;
      id = '0;
      br = '0;
      for (int i = 0; i < 64; i++) begin
         t = (!ea | a[i]) & (!eb | b[i]);
         c = (!ea | !a[i]) & (!eb | !b[i]);
         id[i] = (!t && !c) ? path[i] : t;
         br[i] = !t && !c;
         if (a[i] != id[i]) ea = 1'b0;
         if (b[i] != id[i]) eb = 1'b0;
      end
   endfunction : ref_search

   task automatic close_out();
      $display("checks=%0d mismatches=%0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : close_out

   task automatic wait_done();
      int n;
      n = 0;
      while (op_done !== 1'b1 && n < 40000) begin
         @(negedge clk_sys);
         n++;
      end
      if (n >= 40000) `CHK(1'b0, 1'b1)
   endtask : wait_done

   task automatic start_op(input swm_op_e op, input logic [63:0] path);
      @(posedge clk_sys);
      op_code <= op;
      search_path <= path;
      op_valid <= 1'b1;
      @(posedge clk_sys);
      op_valid <= 1'b0;
   endtask : start_op

   task automatic chk_idle();
      `CHK({op_ready, op_done, present, crc_ok}, 4'h8)
      `CHK({rom_id, branch_mask}, 128'h0)
      `CHK({line_oe, line_out}, 2'h0)
   endtask : chk_idle

   // Reset pulse length and slot spacing seen on the master's drive
   always @(posedge clk_sys) begin
      gap++;
      if (!rst_n) gap = 1000000;
      if (line_oe === 1'b1) begin
         if (run_len == 0 && gap < min_gap) min_gap = gap;
         if (run_len == 0) gap = 0;
         run_len++;
      end else if (run_len > 0) begin
         if (run_len > max_low) max_low = run_len;
         run_len = 0;
      end
   end

   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   // Whole run is roughly 60k cycles of line traffic
   initial begin
      #(500_000);
      miscompares++;
      close_out();
   end

   // ********************************************************
   // Main sequence
   // ********************************************************
   initial begin
      rst_n = 1'b0;
      op_valid = 1'b0;
      op_code = SWM_OP_READ;
      search_path = '0;
      en_a = 1'b1;
      en_b = 1'b0;
      ida = {8'h00, SER_A, FAM};
      ida[63:56] = crc8(ida, 56);
      idb = {8'h00, SER_B, FAM};
      idb[63:56] = crc8(idb, 56);
      rows = '{'{SWM_OP_READ, 1'b1, 1'b0, '0},
               '{SWM_OP_SEARCH, 1'b1, 1'b1, '0},
               '{SWM_OP_SEARCH, 1'b1, 1'b1, '1},
               '{SWM_OP_READ, 1'b1, 1'b1, '0},
               '{SWM_OP_READ, 1'b0, 1'b0, '0}};
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(negedge clk_sys);
      chk_idle();
      foreach (rows[i]) begin
         en_a <= rows[i].ea;
         en_b <= rows[i].eb;
         pres = rows[i].ea | rows[i].eb;
         ebr = '0;
         if (rows[i].op == SWM_OP_SEARCH)
            ref_search(ida, idb, rows[i].ea, rows[i].eb, rows[i].path,
                       eid, ebr);
         else
            eid = (rows[i].ea ? ida : '1) & (rows[i].eb ? idb : '1);
         if (!pres) eid = '0;
         start_op(rows[i].op, rows[i].path);
         wait_done();
         `CHK(present, pres)
         `CHK(rom_id, eid)
         `CHK(branch_mask, ebr)
         `CHK(crc_ok, pres && crc8(eid, 64) === 8'h00)
      end
      // A device lost mid-search leaves both reads high: pass is void
      en_a <= 1'b1;
      en_b <= 1'b0;
      start_op(SWM_OP_SEARCH, '0);
      repeat (2000) @(posedge clk_sys);
      en_a <= 1'b0;
      wait_done();
      `CHK({present, crc_ok}, 2'h0)
      // Abort in the middle of the command byte, then back-to-back reads
      en_a <= 1'b1;
      start_op(SWM_OP_READ, '0);
      repeat (1250) @(posedge clk_sys);
      rst_n <= 1'b0;
      @(negedge clk_sys);
      chk_idle();
      @(posedge clk_sys);
      rst_n <= 1'b1;
      op_valid <= 1'b1;
      wait_done();
      `CHK(op_ready, 1'b1)
      `CHK(rom_id, ida)
      @(posedge clk_sys);
      op_valid <= 1'b0;
      @(negedge clk_sys);
      `CHK(op_ready, 1'b0)
      wait_done();
      `CHK(rom_id, ida)
      `CHK(crc_ok, 1'b1)
      `CHK(max_low >= 480 * US_CYC, 1'b1)
      `CHK(min_gap * 163 >= 10000 * US_CYC, 1'b1)
      close_out();
   end
endmodule : swm_master_tb

`default_nettype wire
